// file: rtl/spi_cfg.svh
// Constants for the switch position indication block
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH
`define SPI_CLK_HZ          40000000
`define SPI_TICK_NS         1000000
`define SPI_CLK_NS          25
`define SPI_TICK_CYCLES     (`SPI_TICK_NS / `SPI_CLK_NS)
`define SPI_TICK_W          16
`define SPI_MS_W            16
`define SPI_EVT_DELAY_MAX   16'hEA60
`define SPI_EVT_DELAY_RST   16'h7530
`define SPI_FILT_RST        16'h000A
`endif

// file: rtl/spi_pkg.sv
// Types for the switch position indication block
package spi_pkg;
    typedef enum logic [1:0] {
        SPI_POS_INTERMEDIATE = 2'h0,
        SPI_POS_OPEN         = 2'h1,
        SPI_POS_CLOSED       = 2'h2,
        SPI_POS_FAULTY       = 2'h3
    } spi_pos_type;

    typedef struct packed {
        logic open_indication;
        logic closed_indication;
        logic position_valid;
    } spi_ind_type;

    typedef struct packed {
        logic open_valid;
        logic closed_valid;
    } spi_qual_type;
endpackage

// file: rtl/spi_switch_position.sv
// Switch position decoder with per-input debounce and intermediate event delay
`timescale 1ns/1ps
`include "spi_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module spi_switch_position (
    input  wire logic                  clock_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  open_contact_in,
    input  wire logic                  closed_contact_in,
    input  wire logic                  open_valid_in,
    input  wire logic                  closed_valid_in,
    input  wire logic [`SPI_MS_W-1:0]  open_filter_ms_in,
    input  wire logic [`SPI_MS_W-1:0]  closed_filter_ms_in,
    input  wire logic [`SPI_MS_W-1:0]  event_delay_ms_in,
    output spi_pkg::spi_pos_type       position_out,
    output spi_pkg::spi_ind_type       indication_out,
    output spi_pkg::spi_qual_type      indication_qual_out,
    output logic                       intermediate_event_out,
    output spi_pkg::spi_qual_type      event_qual_out
);

    localparam logic [`SPI_TICK_W-1:0] TICK_LAST = `SPI_TICK_W'(`SPI_TICK_CYCLES - 1);

    logic [1:0]             sync1_q, sync1_d, sync2_q, sync2_d;
    logic [1:0]             qsync1_q, qsync1_d, qsync2_q, qsync2_d;
    logic [`SPI_TICK_W-1:0] tick_cnt_q, tick_cnt_d;
    logic                   tick_q, tick_d;
    logic [1:0]             filt_q, filt_d;
    logic [`SPI_MS_W-1:0]   fcnt_q [2];
    logic [`SPI_MS_W-1:0]   fcnt_d [2];
    logic [`SPI_MS_W-1:0]   fset [2];
    logic [`SPI_MS_W-1:0]   delay_q, delay_d, delay_lim;
    logic                   delay_done_q, delay_done_d;
    spi_pkg::spi_pos_type   pos_q, pos_d, dec;
    spi_pkg::spi_ind_type   ind_q, ind_d;
    spi_pkg::spi_qual_type  qual_q, qual_d, equal_q, equal_d;
    logic                   evt_q, evt_d;

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers; pins float low when unwired, so idle is intermediate
    always_comb begin
        sync1_d  = {closed_contact_in, open_contact_in};
        sync2_d  = sync1_q;
        qsync1_d = {closed_valid_in, open_valid_in};
        qsync2_d = qsync1_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick from the 40 MHz clock
    always_comb begin
        tick_d     = 1'b0;
        tick_cnt_d = tick_cnt_q + `SPI_TICK_W'(1);
        if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debounce: a new level must hold for its own filter count of ms ticks; the first tick may fall at once, so up to 1 ms less
    assign fset[0] = open_filter_ms_in;
    assign fset[1] = closed_filter_ms_in;
    always_comb begin
        filt_d = filt_q;
        for (int i = 0; i < 2; i++) begin
            fcnt_d[i] = fcnt_q[i];
            if (sync2_q[i] == filt_q[i]) begin
                fcnt_d[i] = '0; // Any bounce back restarts the window
            end else if (fcnt_q[i] >= fset[i]) begin
                filt_d[i] = sync2_q[i];
                fcnt_d[i] = '0;
            end else if (tick_q) begin
                fcnt_d[i] = fcnt_q[i] + `SPI_MS_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode and indications; both switch kinds share this block unchanged
    always_comb begin
        case (filt_q)
            2'b01:   dec = spi_pkg::SPI_POS_OPEN;
            2'b10:   dec = spi_pkg::SPI_POS_CLOSED;
            2'b11:   dec = spi_pkg::SPI_POS_FAULTY;
            default: dec = spi_pkg::SPI_POS_INTERMEDIATE;
        endcase
        pos_d                   = dec;
        ind_d.open_indication   = (dec == spi_pkg::SPI_POS_OPEN);
        ind_d.closed_indication = (dec == spi_pkg::SPI_POS_CLOSED);
        ind_d.position_valid    = ind_d.open_indication | ind_d.closed_indication;
        qual_d                  = {qsync2_q[0], qsync2_q[1]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Intermediate event delay; setting clamped to its top so a bad value cannot hang
    // The first tick may fall right after entry, so one extra tick is counted:
    // the event lands between D and D+1 ms and never early. Zero still fires at once.
    assign delay_lim = (event_delay_ms_in > `SPI_EVT_DELAY_MAX) ? `SPI_EVT_DELAY_MAX : event_delay_ms_in;
    always_comb begin
        delay_d      = delay_q;
        delay_done_d = delay_done_q;
        evt_d        = 1'b0;
        equal_d      = equal_q;
        if (pos_q != spi_pkg::SPI_POS_INTERMEDIATE) begin
            delay_d      = '0;
            delay_done_d = 1'b0;
        end else if (!delay_done_q) begin
            if ((delay_lim == '0) || (delay_q > delay_lim)) begin
                evt_d        = 1'b1;
                delay_done_d = 1'b1;
                equal_d      = qual_q;
            end else if (tick_q) begin
                delay_d = delay_q + `SPI_MS_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers; synchronous reset
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            sync1_q      <= '0;
            sync2_q      <= '0;
            qsync1_q     <= '0;
            qsync2_q     <= '0;
            tick_cnt_q   <= '0;
            tick_q       <= 1'b0;
            filt_q       <= '0;
            fcnt_q[0]    <= '0;
            fcnt_q[1]    <= '0;
            delay_q      <= '0;
            delay_done_q <= 1'b0;
            pos_q        <= spi_pkg::SPI_POS_INTERMEDIATE;
            ind_q        <= '0;
            qual_q       <= '0;
            equal_q      <= '0;
            evt_q        <= 1'b0;
        end else begin
            sync1_q      <= sync1_d;
            sync2_q      <= sync2_d;
            qsync1_q     <= qsync1_d;
            qsync2_q     <= qsync2_d;
            tick_cnt_q   <= tick_cnt_d;
            tick_q       <= tick_d;
            filt_q       <= filt_d;
            fcnt_q[0]    <= fcnt_d[0];
            fcnt_q[1]    <= fcnt_d[1];
            delay_q      <= delay_d;
            delay_done_q <= delay_done_d;
            pos_q        <= pos_d;
            ind_q        <= ind_d;
            qual_q       <= qual_d;
            equal_q      <= equal_d;
            evt_q        <= evt_d;
        end
    end

    assign position_out           = pos_q;
    assign indication_out         = ind_q;
    assign indication_qual_out    = qual_q;
    assign intermediate_event_out = evt_q;
    assign event_qual_out         = equal_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence seq_stable_open;
        filt_q == 2'b01 ##1 1'b1;
    endsequence

    AST_OPEN_DECODE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        seq_stable_open |-> pos_q == spi_pkg::SPI_POS_OPEN && ind_q.open_indication && !ind_q.closed_indication)
        else $error("open contact not decoded as open");
    AST_CLOSED_DECODE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        filt_q == 2'b10 |=> pos_q == spi_pkg::SPI_POS_CLOSED && ind_q.closed_indication && !ind_q.open_indication)
        else $error("closed contact not decoded as closed");
    AST_FAULTY: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        filt_q == 2'b11 |=> pos_q == spi_pkg::SPI_POS_FAULTY && ind_q == '0)
        else $error("faulty state drives an indication");
    AST_INTERMEDIATE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        filt_q == 2'b00 |=> pos_q == spi_pkg::SPI_POS_INTERMEDIATE && ind_q == '0)
        else $error("intermediate state drives an indication");
    AST_VALID: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        ind_q.position_valid == (pos_q == spi_pkg::SPI_POS_OPEN || pos_q == spi_pkg::SPI_POS_CLOSED))
        else $error("position valid disagrees with position");
    AST_FILTER_HOLD: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        filt_q[0] != $past(filt_q[0]) |-> $past(fcnt_q[0]) >= $past(open_filter_ms_in))
        else $error("open filter changed before its time");
    AST_EVENT_CAUSE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        evt_q |-> $past(pos_q) == spi_pkg::SPI_POS_INTERMEDIATE
                  && ($past(delay_lim) == '0 || $past(delay_q) > $past(delay_lim)))
        else $error("intermediate event before delay elapsed");
    AST_TIMER_RESTART: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        pos_q != spi_pkg::SPI_POS_INTERMEDIATE |=> delay_q == '0 && !evt_q)
        else $error("delay timer not restarted");
    AST_QUAL_PASS: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        evt_q |-> event_qual_out == $past(qual_q))
        else $error("event qualifier not attached");
    AST_FILTER_HOLD_CLOSED: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        filt_q[1] != $past(filt_q[1]) |-> $past(fcnt_q[1]) >= $past(closed_filter_ms_in))
        else $error("closed filter changed before its time");
    AST_EVENT_PULSE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        evt_q |=> !evt_q)
        else $error("intermediate event longer than one cycle");
    AST_EVENT_ONCE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        delay_done_q && pos_q == spi_pkg::SPI_POS_INTERMEDIATE |=> !evt_q)
        else $error("intermediate event repeated");

    // Entry into intermediate from any other decoded state
    sequence seq_enter_intermediate;
        pos_q != spi_pkg::SPI_POS_INTERMEDIATE ##1 pos_q == spi_pkg::SPI_POS_INTERMEDIATE;
    endsequence

    AST_EVENT_ZERO_DELAY: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        seq_enter_intermediate ##0 delay_lim == '0 |=> evt_q)
        else $error("zero delay event missing");

endmodule

// file: test/spi_contact_model.sv
// Behavioural model of the switchgear auxiliary position contacts
`timescale 1ns/1ps
module spi_contact_model (
    input  wire logic clock_in,
    input  wire logic want_open_in,
    input  wire logic want_closed_in,
    input  wire logic slow_in,
    output logic      open_contact_out,
    output logic      closed_contact_out
);
    logic [1:0] want_q [5] = '{default: 2'h0};
    logic       slow_q     = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // Requests are taken on the rising edge so they never race the bench's falling-edge writes
    always @(posedge clock_in) begin
        want_q <= '{{want_open_in, want_closed_in}, want_q[0], want_q[1], want_q[2], want_q[3]};
        slow_q <= slow_in;
    end
    // A slow switch lands four cycles late; the pipeline starts at zero so unwired lines read false
    always @(negedge clock_in) begin
        {open_contact_out, closed_contact_out} <= slow_q ? want_q[4] : want_q[0];
    end
endmodule

// file: test/spi_switch_position_tb.sv
// Self-checking bench for the switch position decoder
`timescale 1ns/1ps
`include "spi_cfg.svh"
module spi_switch_position_tb;
    logic                  clock_in = 1'b0, reset_n_in = 1'b0, slow = 1'b0, evt_d = 1'b0, armed = 1'b0;
    logic                  want_open = 1'b0, want_closed = 1'b0, open_ok = 1'b1, closed_ok = 1'b1;
    logic                  open_c, closed_c, evt;
    logic [15:0]           open_filt = 16'h0000, closed_filt = 16'h0000, delay_ms = 16'h0000;
    logic [1:0]            last_pos = 2'h0, cur = 2'h0;
    logic [16:0]           lfsr = 17'h148BD;
    logic [3:0]            seq [5] = '{4'hB, 4'hE, 4'h1, 4'h7, 4'h3};
    logic [3:0]            pos_notes[$];
    logic [1:0]            evt_notes[$];
    int                    since = 0, bad_count = 0, tests_run = 0;
    spi_pkg::spi_pos_type  position;
    spi_pkg::spi_ind_type  ind;
    spi_pkg::spi_qual_type ind_q, evt_q;
    always #12.5 clock_in = ~clock_in;
    spi_contact_model spi_contact_model_inst (.clock_in(clock_in), .want_open_in(want_open),
        .want_closed_in(want_closed), .slow_in(slow), .open_contact_out(open_c), .closed_contact_out(closed_c));
    spi_switch_position spi_switch_position_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .open_contact_in(open_c), .closed_contact_in(closed_c), .open_valid_in(open_ok),
        .closed_valid_in(closed_ok), .open_filter_ms_in(open_filt), .closed_filter_ms_in(closed_filt),
        .event_delay_ms_in(delay_ms), .position_out(position), .indication_out(ind),
        .indication_qual_out(ind_q), .intermediate_event_out(evt), .event_qual_out(evt_q));
    ////////////////////////////////////////////////////////////////////////////////
    // Shared comparison, counts every call
    task automatic check(string what, logic [3:0] seen, logic [3:0] want);
        tests_run++;
        if (seen !== want) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask
    function automatic logic [16:0] nxt(logic [16:0] x);
        return {x[15:0], x[16] ^ x[13]};
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Moves the switch and posts what must follow; 14 cycles covers travel, sync and a zero-delay event
    task automatic step(logic [3:0] v);
        @(negedge clock_in);
        {want_open, want_closed, open_ok, closed_ok} = v;
        if ({v[2], v[3]} != cur) pos_notes.push_back({v[2], v[3], v[1:0]});
        if (v[3:2] == 2'h0 && cur != 2'h0) evt_notes.push_back(v[1:0]);
        cur = {v[2], v[3]};
        repeat (14) @(negedge clock_in);
    endtask
    // Each position change takes the oldest note; the event is judged a cycle after its pulse
    always @(negedge clock_in) begin : mon
        logic [3:0] n;
        evt_d <= evt;
        since <= (position !== last_pos) ? 0 : since + 1;
        last_pos <= position;
        if (!reset_n_in) armed <= 1'b0;
        else if (position !== last_pos) begin
            armed <= 1'b1;
            n = pos_notes.size() ? pos_notes.pop_front() : 4'hX;
            check("position", {position, ind_q}, n);
            check("indication", {1'b0, ind}, {1'b0, n[3:2] == 2'h1, n[3:2] == 2'h2, ^n[3:2]});
        end
        // Right after reset an idle block may already report intermediate, so only later ones count
        if (evt_d && (armed || evt_notes.size() > 0)) begin
            check("event", {position, evt_q}, {2'h0, evt_notes.size() ? evt_notes.pop_front() : 2'hX});
            if (delay_ms == 16'h0001) check("event delay", {3'h0, since > 39000 && since < 80100}, 4'h1);
        end
    end
    // Longest clean run is about 81000 cycles, most of it the event wait of up to 2 ms
    initial begin
        #2400000;
        bad_count++;
        finish_test();
    end
    initial begin : main
        repeat (16) @(posedge clock_in);
        @(negedge clock_in);
        reset_n_in = 1'b1;
        check("reset", {position, ind_q}, 4'h0);
        check("reset indication", {1'b0, ind}, 4'h0);
        // Every code promptly, then with travel, then a random walk
        for (int i = 0; i < 50; i++) begin
            lfsr = nxt(lfsr);
            slow = i < 5 ? 1'b0 : (i < 10 ? 1'b1 : lfsr[4]);
            step(i < 10 ? seq[i % 5] : lfsr[3:0]);
        end
        // A blip shorter than the filter window must leave the position alone
        slow = 1'b0;
        step(4'h3);
        open_filt = 16'h0002;
        closed_filt = 16'h0003;
        want_open = 1'b1;
        want_closed = 1'b1;
        repeat (100) @(negedge clock_in);
        want_open = 1'b0;
        want_closed = 1'b0;
        repeat (200) @(negedge clock_in);
        check("blip", {2'h0, position}, 4'h0);
        open_filt = 16'h0000;
        closed_filt = 16'h0000;
        delay_ms = 16'h0001;
        step(4'hB);
        step(4'h2);
        for (int k = 0; k < 85000 && evt_notes.size() > 0; k++) @(negedge clock_in);
        check("notes left", 4'(pos_notes.size() + evt_notes.size()), 4'h0);
        finish_test();
    end
endmodule
